// >>> hdl/dpc_defs.svh
// Register offsets, field positions, reset values and counts of the PLL/cal control
`ifndef DPC_DEFS_SVH
`define DPC_DEFS_SVH

`define DPC_ADDR_W          10
`define DPC_A_POWER         10'h011
`define DPC_A_IRQ_EN        10'h01f
`define DPC_A_IRQ_ST        10'h023
`define DPC_A_GAIN0_A       10'h040
`define DPC_A_GAIN0_B       10'h041
`define DPC_A_GAIN1_A       10'h044
`define DPC_A_GAIN1_B       10'h045
`define DPC_A_PLL_CTL       10'h083
`define DPC_A_PLL_ST        10'h084
`define DPC_A_LOOP_DIV      10'h085
`define DPC_A_VCO_DIV       10'h08b
`define DPC_A_REF_DIV       10'h08c
`define DPC_A_CAL_CLK       10'h0e7
`define DPC_A_CAL_SEL       10'h0e8
`define DPC_A_CAL_CTL       10'h0e9
`define DPC_A_CAL_INIT      10'h0ed
`define DPC_A_TEMP_EN       10'h12f
`define DPC_A_TEMP_LO       10'h132
`define DPC_A_TEMP_HI       10'h133
`define DPC_A_TEMP_CAP      10'h134

`define DPC_B_PLL_EN        4
`define DPC_B_PLL_RECAL     7
`define DPC_B_ST_UPPER      7
`define DPC_B_ST_LOWER      6
`define DPC_B_ST_CPDONE     5
`define DPC_B_ST_LOCK       1
`define DPC_B_IRQ_LOCK      5
`define DPC_B_IRQ_LOST      4
`define DPC_B_PD_DAC0       6
`define DPC_B_PD_DAC1       4
`define DPC_B_CAL_EN        0
`define DPC_B_CAL_START     1
`define DPC_B_CALCLK_RUN    3

`define DPC_LOOP_MIN        8'h06
`define DPC_LOOP_MAX        8'h7f
`define DPC_VCO_MIN         2'h1
`define DPC_REF_MAX         3'h5

`define DPC_RST_BYTE        8'h00
`define DPC_RST_LOOP        8'h10
`define DPC_RST_VCO         2'h2
`define DPC_RST_REF         3'h0

`define DPC_CP_CAL_TICKS    64
`define DPC_CAL_CYCLES      256

`endif

// >>> hdl/dpc_pkg.sv
// Types shared by the PLL and calibration control logic
package dpc_pkg;

	typedef enum logic [1:0] {
		CAL_IDLE  = 2'b00,
		CAL_ARMED = 2'b01,
		CAL_RUN   = 2'b11,
		CAL_DONE  = 2'b10
	} dpc_cal_state_t;

	typedef struct packed {
		logic       enable;
		logic       recal_pulse;
		logic [1:0] vco_output_divide_field;
		logic [4:0] vco_output_divide_ratio;
		logic [7:0] loop_divide_ratio;
		logic [2:0] reference_divide_field;
		logic [5:0] reference_divide_ratio;
	} dpc_pll_cfg_t;

	typedef struct packed {
		logic upper_edge;
		logic lower_edge;
		logic locked;
	} dpc_pll_stat_t;

	typedef struct packed {
		logic [1:0] msb;
		logic [7:0] lsb;
	} dpc_gain_t;

	typedef struct packed {
		logic       done;
		logic [2:0] fault;
	} dpc_cal_res_t;

endpackage

// >>> hdl/dpc_top.sv
// Register-level PLL, gain, power, self-calibration and temperature control
`timescale 1ns/1ps
`include "dpc_defs.svh"

// How it works
// (R01) Software writes fixed PLL settings, then the two-bit VCO divide field.
// (R02) Software sets loop divide ratio so phase detector input is 35-80 MHz.
// (R03) Software writes the three-bit reference divide field before PLL enable.
// (R04) Control bit 4 starts the PLL; software sets it after all settings.
// (R05) Status bit 5 shows PLL calibration finished with a valid result.
// (R06) Status bit 1 follows the PLL lock indication.
// (R07) Status bits 7 and 6 show upper and lower band edge reached.
// (R08) Clearing then setting control bit 7 triggers a PLL recalibration.
// (R09) Lock and lost events are gated by enable bits 5 and 4.
// (R10) Lock and lost pending bits 5 and 4 clear by writing ones.
// (R11) Each DAC holds a 10-bit gain code split over two byte registers.
// (R12) Unsigned samples pass straight; all ones is maximum output.
// (R13) Two's-complement samples are offset by half span via MSB flip.
// (R14) Power bit 6 powers down DAC0, bit 4 powers down DAC1.
// (R15) Software keeps power bits 7 and 2 low for band gap and bias.
// (R16) Calibration write order: clock 0x38, select, 0xa2, 0x01, 0x03, 0x30.
// (R17) Select bit 2 for DAC1, bit 0 for DAC0; bits 3 and 1 stay low.
// (R18) Page-selected DAC reports done in bit 7, faults in bits 6 to 4.
// (R19) Software powers DACs down during calibration and repeats after drift.
// (R20) Temperature sensor stays off until enable bit 0 is set.
// (R21) Writing capture bit 0 latches the temperature code into two bytes.
// (R22) Charge pump calibration runs 64 reference ticks once, then is held.
// (R23) VCO divide field values 1, 2, 3 mean divide by 4, 8, 16.
// (R24) Loop divide ratio writes outside 6 to 127 are ignored.
// (R25) Reference divide field 0 to 5 gives ratio two to that power.
// (R26) Pending PLL event bits stay set until software clears them.
module dpc_top
	import dpc_pkg::*;
#(
	parameter int CAL_CYCLES = `DPC_CAL_CYCLES,
	parameter int SAMPLE_W   = 16,
	parameter int TEMP_W     = 16
) (
	// Clock and reset
	input  wire logic                      sys_clk,
	input  wire logic                      rst_n,
	// Configuration register port
	input  wire logic [`DPC_ADDR_W-1:0]    reg_addr,
	input  wire logic [7:0]                reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic      [7:0]                reg_rdata,
	// PLL analog side
	input  wire logic                      ref_tick,
	input  wire dpc_pll_stat_t             pll_stat,
	output dpc_pll_cfg_t                   pll_cfg,
	output logic                           cp_cal_run,
	// DAC controls
	output logic      [1:0]                dac_power_down,
	output dpc_gain_t [1:0]                full_scale_gain_code,
	// Self-calibration engine
	input  wire logic [1:0][2:0]           cal_fault,
	output logic                           cal_clock_run,
	output logic      [1:0]                cal_running,
	output logic      [7:0]                cal_initial_code,
	// Temperature sensor
	input  wire logic [TEMP_W-1:0]         temp_code_in,
	output logic                           temp_sensor_on,
	output logic                           temp_capture_pulse,
	// Sample format
	input  wire logic                      twos_mode,
	input  wire logic [SAMPLE_W-1:0]       sample_in,
	output logic      [SAMPLE_W-1:0]       sample_code
);

	localparam int CW = $clog2(CAL_CYCLES + 1);
	localparam logic [CW-1:0] CAL_LAST = CW'(CAL_CYCLES - 1);
	localparam logic [6:0]    CP_LAST  = 7'(`DPC_CP_CAL_TICKS - 1);

	generate
		if (CAL_CYCLES < 1 || TEMP_W > 16 || TEMP_W < 9 || SAMPLE_W < 2) begin : g_bad
			$error("dpc_top: unsupported parameter value");
		end
	endgenerate

	logic [7:0]          power_ctl;
	logic [7:0]          irq_en;
	logic [7:0]          irq_st;
	logic [7:0]          pll_ctl;
	logic [7:0]          cal_clk_cfg;
	logic [7:0]          cal_sel;
	logic [1:0]          cal_ctl_bits;
	logic [1:0]          cal_run_sel;
	logic [CW-1:0]       cal_cnt;
	logic [6:0]          cp_cnt;
	logic                cp_done;
	logic                lock_q;
	logic                temp_en;
	logic [15:0]         temp_code;
	dpc_cal_state_t      cal_state;
	dpc_cal_state_t      next_cal_state;
	dpc_cal_res_t [1:0]  cal_res;
	logic [7:0]          rd_mux;
	logic [7:0]          loop_ratio;
	logic [1:0]          vco_field;
	logic [2:0]          ref_field;
	logic                recal_q;

	// Write strobes
	wire wr_power   = reg_wr && reg_addr == `DPC_A_POWER;
	wire wr_irq_en  = reg_wr && reg_addr == `DPC_A_IRQ_EN;
	wire wr_irq_st  = reg_wr && reg_addr == `DPC_A_IRQ_ST;
	wire wr_pll_ctl = reg_wr && reg_addr == `DPC_A_PLL_CTL;
	wire wr_loop    = reg_wr && reg_addr == `DPC_A_LOOP_DIV;
	wire wr_vco     = reg_wr && reg_addr == `DPC_A_VCO_DIV;
	wire wr_ref     = reg_wr && reg_addr == `DPC_A_REF_DIV;
	wire wr_cal_clk = reg_wr && reg_addr == `DPC_A_CAL_CLK;
	wire wr_cal_sel = reg_wr && reg_addr == `DPC_A_CAL_SEL;
	wire wr_cal_ctl = reg_wr && reg_addr == `DPC_A_CAL_CTL;
	wire wr_cal_ini = reg_wr && reg_addr == `DPC_A_CAL_INIT;
	wire wr_temp_en = reg_wr && reg_addr == `DPC_A_TEMP_EN;
	wire wr_temp_cp = reg_wr && reg_addr == `DPC_A_TEMP_CAP;

	// Field validity
	wire loop_ok = reg_wdata >= `DPC_LOOP_MIN && reg_wdata <= `DPC_LOOP_MAX;
	wire vco_ok  = reg_wdata[1:0] >= `DPC_VCO_MIN;
	wire ref_ok  = reg_wdata[2:0] <= `DPC_REF_MAX;

	// PLL events
	wire lock_rise  = pll_stat.locked && !lock_q;
	wire lock_fall  = !pll_stat.locked && lock_q;
	wire set_lock   = lock_rise && irq_en[`DPC_B_IRQ_LOCK];
	wire set_lost   = lock_fall && irq_en[`DPC_B_IRQ_LOST];
	wire clr_lock   = wr_irq_st && reg_wdata[`DPC_B_IRQ_LOCK];
	wire clr_lost   = wr_irq_st && reg_wdata[`DPC_B_IRQ_LOST];
	wire recal_edge = wr_pll_ctl && reg_wdata[`DPC_B_PLL_RECAL]
		&& !pll_ctl[`DPC_B_PLL_RECAL];
	wire cp_step    = ref_tick && cp_cal_run;

	// Calibration sequencing
	wire cal_tick   = cal_state == CAL_RUN && cal_clk_cfg[`DPC_B_CALCLK_RUN];
	wire cal_finish = cal_tick && cal_cnt == CAL_LAST;
	wire cal_start  = wr_cal_ctl && reg_wdata[`DPC_B_CAL_EN]
		&& reg_wdata[`DPC_B_CAL_START] && cal_state != CAL_RUN;
	wire [1:0] sel_now = {cal_sel[2], cal_sel[0]};
	wire [1:0] page    = sel_now;
	wire temp_take  = wr_temp_cp && reg_wdata[0] && temp_en;

	// Power, enables and PLL dividers
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			power_ctl <= `DPC_RST_BYTE;
			irq_en    <= `DPC_RST_BYTE;
			pll_ctl   <= `DPC_RST_BYTE;
			temp_en   <= 1'b0;
		end else begin
			if (wr_power)
				power_ctl <= reg_wdata;
			if (wr_irq_en)
				irq_en <= reg_wdata;
			if (wr_pll_ctl)
				pll_ctl <= reg_wdata;
			if (wr_temp_en)
				temp_en <= reg_wdata[0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			loop_ratio <= `DPC_RST_LOOP;
			vco_field  <= `DPC_RST_VCO;
			ref_field  <= `DPC_RST_REF;
		end else begin
			if (wr_loop && loop_ok)
				loop_ratio <= reg_wdata; // [R24]
			if (wr_vco && vco_ok)
				vco_field <= reg_wdata[1:0]; // [R23]
			if (wr_ref && ref_ok)
				ref_field <= reg_wdata[2:0]; // [R25]
		end
	end

	// Divide by 16 needs a shift of four, so widen before adding
	wire [4:0] vco_ratio = 5'd1 << ({1'b0, vco_field} + 3'd1); // [R23]
	wire [5:0] ref_ratio = 6'd1 << ref_field; // [R25]
	assign pll_cfg = '{
		enable:                  pll_ctl[`DPC_B_PLL_EN], // [R04]
		recal_pulse:             recal_q, // [R08]
		vco_output_divide_field: vco_field,
		vco_output_divide_ratio: vco_ratio,
		loop_divide_ratio:       loop_ratio,
		reference_divide_field:  ref_field,
		reference_divide_ratio:  ref_ratio
	};
	assign dac_power_down = {power_ctl[`DPC_B_PD_DAC1],
		power_ctl[`DPC_B_PD_DAC0]}; // [R14]
	assign temp_sensor_on = temp_en; // [R20]
	assign cp_cal_run = pll_cfg.enable && !cp_done;

	// Recalibration pulse and charge pump calibration
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			recal_q             <= 1'b0;
			cp_cnt              <= 7'h00;
			cp_done             <= 1'b0;
			lock_q              <= 1'b0;
		end else begin
			recal_q             <= recal_edge; // [R08]
			lock_q              <= pll_stat.locked;
			if (cp_step) begin
				cp_cnt <= cp_cnt + 7'h01; // [R22]
				if (cp_cnt == CP_LAST)
					cp_done <= 1'b1; // [R22]
			end
		end
	end

	// Sticky event bits, set wins over clear
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			irq_st <= `DPC_RST_BYTE;
		end else begin
			irq_st[`DPC_B_IRQ_LOCK] <= set_lock
				|| (irq_st[`DPC_B_IRQ_LOCK] && !clr_lock); // [R09] [R10] [R26]
			irq_st[`DPC_B_IRQ_LOST] <= set_lost
				|| (irq_st[`DPC_B_IRQ_LOST] && !clr_lost); // [R09] [R10] [R26]
		end
	end

	// Calibration configuration
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cal_clk_cfg      <= `DPC_RST_BYTE;
			cal_sel          <= `DPC_RST_BYTE;
			cal_initial_code <= `DPC_RST_BYTE;
			cal_ctl_bits     <= 2'h0;
		end else begin
			if (wr_cal_clk)
				cal_clk_cfg <= reg_wdata;
			if (wr_cal_sel)
				cal_sel <= reg_wdata;
			if (wr_cal_ini)
				cal_initial_code <= reg_wdata;
			if (wr_cal_ctl)
				cal_ctl_bits <= reg_wdata[1:0];
		end
	end

	assign cal_clock_run = cal_clk_cfg[`DPC_B_CALCLK_RUN];

	always_comb begin
		next_cal_state = cal_state;
		case (cal_state)
			CAL_IDLE: begin
				if (cal_start)
					next_cal_state = CAL_RUN;
				else if (wr_cal_ctl && reg_wdata[`DPC_B_CAL_EN])
					next_cal_state = CAL_ARMED;
			end
			CAL_ARMED, CAL_DONE: begin
				if (wr_cal_ctl && !reg_wdata[`DPC_B_CAL_EN])
					next_cal_state = CAL_IDLE;
				else if (cal_start)
					next_cal_state = CAL_RUN;
			end
			CAL_RUN: begin
				if (wr_cal_ctl && !reg_wdata[`DPC_B_CAL_EN])
					next_cal_state = CAL_IDLE;
				else if (cal_finish)
					next_cal_state = CAL_DONE;
			end
			default: next_cal_state = CAL_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cal_state   <= CAL_IDLE;
			cal_cnt     <= '0;
			cal_run_sel <= 2'h0;
		end else begin
			cal_state <= next_cal_state;
			if (cal_start) begin
				cal_cnt     <= '0;
				cal_run_sel <= sel_now;
			end else if (cal_tick) begin
				cal_cnt <= cal_cnt + CW'(1);
			end
		end
	end

	// Per-DAC gain code and calibration result
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_dac
			wire wr_a = reg_wr && reg_addr ==
				(g == 0 ? `DPC_A_GAIN0_A : `DPC_A_GAIN1_A);
			wire wr_b = reg_wr && reg_addr ==
				(g == 0 ? `DPC_A_GAIN0_B : `DPC_A_GAIN1_B);
			always_ff @(posedge sys_clk) begin
				if (!rst_n) begin
					full_scale_gain_code[g] <= '0;
					cal_res[g]              <= '0;
				end else begin
					if (wr_a)
						full_scale_gain_code[g].msb <= reg_wdata[1:0]; // [R11]
					if (wr_b)
						full_scale_gain_code[g].lsb <= reg_wdata; // [R11]
					if (cal_start && sel_now[g])
						cal_res[g] <= '0;
					else if (cal_finish && cal_run_sel[g])
						cal_res[g] <= {1'b1, cal_fault[g]}; // [R18]
				end
			end
			assign cal_running[g] = cal_state == CAL_RUN && cal_run_sel[g];
		end
	endgenerate

	// Temperature capture
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			temp_code          <= 16'h0000;
			temp_capture_pulse <= 1'b0;
		end else begin
			temp_capture_pulse <= temp_take; // [R21]
			if (temp_take)
				temp_code <= 16'(temp_code_in); // [R21]
		end
	end

	// Sample format conversion
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			sample_code <= '0;
		else
			sample_code <= {sample_in[SAMPLE_W-1] ^ twos_mode,
				sample_in[SAMPLE_W-2:0]}; // [R12] [R13]
	end

	// Read data selection
	always_comb begin
		rd_mux = 8'h00;
		if (reg_addr == `DPC_A_POWER)
			rd_mux = power_ctl;
		else if (reg_addr == `DPC_A_IRQ_EN)
			rd_mux = irq_en;
		else if (reg_addr == `DPC_A_IRQ_ST)
			rd_mux = irq_st;
		else if (reg_addr == `DPC_A_GAIN0_A)
			rd_mux = {6'h00, full_scale_gain_code[0].msb};
		else if (reg_addr == `DPC_A_GAIN0_B)
			rd_mux = full_scale_gain_code[0].lsb;
		else if (reg_addr == `DPC_A_GAIN1_A)
			rd_mux = {6'h00, full_scale_gain_code[1].msb};
		else if (reg_addr == `DPC_A_GAIN1_B)
			rd_mux = full_scale_gain_code[1].lsb;
		else if (reg_addr == `DPC_A_PLL_CTL)
			rd_mux = pll_ctl;
		else if (reg_addr == `DPC_A_PLL_ST)
			rd_mux = {pll_stat.upper_edge, pll_stat.lower_edge, cp_done,
				3'h0, pll_stat.locked, 1'b0}; // [R05] [R06] [R07]
		else if (reg_addr == `DPC_A_LOOP_DIV)
			rd_mux = pll_cfg.loop_divide_ratio;
		else if (reg_addr == `DPC_A_VCO_DIV)
			rd_mux = {6'h00, pll_cfg.vco_output_divide_field};
		else if (reg_addr == `DPC_A_REF_DIV)
			rd_mux = {5'h00, pll_cfg.reference_divide_field};
		else if (reg_addr == `DPC_A_CAL_CLK)
			rd_mux = cal_clk_cfg;
		else if (reg_addr == `DPC_A_CAL_SEL)
			rd_mux = cal_sel;
		else if (reg_addr == `DPC_A_CAL_CTL)
			rd_mux = {page[0] ? cal_res[0] : (page[1] ? cal_res[1] : 4'h0),
				2'h0, cal_ctl_bits}; // [R18]
		else if (reg_addr == `DPC_A_CAL_INIT)
			rd_mux = cal_initial_code;
		else if (reg_addr == `DPC_A_TEMP_EN)
			rd_mux = {7'h00, temp_en};
		else if (reg_addr == `DPC_A_TEMP_LO)
			rd_mux = temp_code[7:0];
		else if (reg_addr == `DPC_A_TEMP_HI)
			rd_mux = temp_code[15:8];
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= reg_rd ? rd_mux : 8'h00;
	end

	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence s_recal_clear;
		!pll_ctl[`DPC_B_PLL_RECAL];
	endsequence

	sequence s_recal_set;
		wr_pll_ctl && reg_wdata[`DPC_B_PLL_RECAL];
	endsequence

	chk_cp_cal_length: assert property ($rose(cp_done) |->
		$past(cp_step) && $past(cp_cnt) == CP_LAST) // [R22]
		else $error("charge pump cal did not take 64 ticks");

	chk_cp_done_held: assert property (cp_done |=> cp_done) // [R22]
		else $error("charge pump cal result lost");

	chk_pll_enable_bit: assert property (wr_pll_ctl |=>
		pll_cfg.enable == $past(reg_wdata[`DPC_B_PLL_EN])) // [R04]
		else $error("pll enable does not follow control bit");

	chk_recal_sequence: assert property (s_recal_clear ##0 s_recal_set
		|=> pll_cfg.recal_pulse ##1 !pll_cfg.recal_pulse) // [R08]
		else $error("recal pulse missing after clear then set");

	chk_irq_lock_set: assert property (set_lock |=>
		irq_st[`DPC_B_IRQ_LOCK]) // [R09]
		else $error("enabled lock event not recorded");

	chk_irq_sticky: assert property (irq_st[`DPC_B_IRQ_LOST] && !clr_lost
		|=> irq_st[`DPC_B_IRQ_LOST]) // [R26]
		else $error("lost pending bit dropped without clear");

	chk_irq_clear: assert property (clr_lock && !set_lock |=>
		!irq_st[`DPC_B_IRQ_LOCK]) // [R10]
		else $error("lock pending bit not cleared");

	chk_loop_range: assert property (
		pll_cfg.loop_divide_ratio >= `DPC_LOOP_MIN &&
		pll_cfg.loop_divide_ratio <= `DPC_LOOP_MAX) // [R24]
		else $error("loop divide ratio out of range");

	chk_twos_offset: assert property (twos_mode && sample_in ==
		{1'b1, {(SAMPLE_W-1){1'b0}}} |=> sample_code == '0) // [R13]
		else $error("most negative code not mapped to zero");

	chk_temp_gate: assert property (temp_capture_pulse |->
		$past(temp_en) && temp_code == 16'($past(temp_code_in))) // [R20] [R21]
		else $error("temperature captured while sensor off");

	chk_cal_report: assert property (cal_finish && cal_run_sel[0] |=>
		cal_res[0].done && cal_state == CAL_DONE) // [R18]
		else $error("calibration done not reported");

endmodule // dpc_top

// >>> tb/dpc_top_tb.sv
// Self-checking testbench for the PLL, gain, calibration and temperature control
`timescale 1ns/1ps

module dpc_top_tb;
	import dpc_pkg::*;

	logic            sys_clk;
	logic            rst_n;
	logic [9:0]      reg_addr;
	logic [7:0]      reg_wdata;
	logic            reg_wr;
	logic            reg_rd;
	logic [7:0]      reg_rdata;
	logic            ref_tick;
	dpc_pll_stat_t   pll_stat;
	dpc_pll_cfg_t    pll_cfg;
	logic            cp_cal_run;
	logic [1:0]      dac_power_down;
	dpc_gain_t [1:0] full_scale_gain_code;
	logic [1:0][2:0] cal_fault;
	logic            cal_clock_run;
	logic [1:0]      cal_running;
	logic [7:0]      cal_initial_code;
	logic [15:0]     temp_code_in;
	logic            temp_sensor_on;
	logic            temp_capture_pulse;
	logic            twos_mode;
	logic [15:0]     sample_in;
	logic [15:0]     sample_code;
	int              fails;
	int              tests_run;
	logic [7:0]      rv;

	dpc_top #(.CAL_CYCLES(4), .SAMPLE_W(16), .TEMP_W(16)) dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .ref_tick(ref_tick), .pll_stat(pll_stat),
		.pll_cfg(pll_cfg), .cp_cal_run(cp_cal_run),
		.dac_power_down(dac_power_down),
		.full_scale_gain_code(full_scale_gain_code), .cal_fault(cal_fault),
		.cal_clock_run(cal_clock_run), .cal_running(cal_running),
		.cal_initial_code(cal_initial_code), .temp_code_in(temp_code_in),
		.temp_sensor_on(temp_sensor_on),
		.temp_capture_pulse(temp_capture_pulse), .twos_mode(twos_mode),
		.sample_in(sample_in), .sample_code(sample_code)
	);

	always #12.5 sys_clk = ~sys_clk;

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		reg_addr  = a;
		reg_wdata = d;
		reg_wr    = 1'b1;
		@(negedge sys_clk);
		reg_wr    = 1'b0;
	endtask

	task automatic rd(input logic [9:0] a, output logic [7:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_rd   = 1'b1;
		@(negedge sys_clk);
		d        = reg_rdata;
		reg_rd   = 1'b0;
	endtask

	task automatic cycles(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	task automatic t_reset_values();
		rd(10'h085, rv); check("loop reset", rv, 8'h10);
		rd(10'h08b, rv); check("vco reset", rv, 8'h02);
		rd(10'h08c, rv); check("ref reset", rv, 8'h00);
		check("vco ratio reset", pll_cfg.vco_output_divide_ratio, 5'd8);
		wr(10'h3ff, 8'h5a);
		rd(10'h3ff, rv); check("unmapped", rv, 8'h00);
		$display("test reset values done");
	endtask

	task automatic t_dividers();
		logic [4:0] vexp [3] = '{5'd4, 5'd8, 5'd16};
		for (int i = 1; i <= 3; i++) begin
			wr(10'h08b, 8'(i));
			check("vco ratio", pll_cfg.vco_output_divide_ratio, vexp[i-1]);
		end
		wr(10'h08b, 8'h00);
		check("vco zero dropped", pll_cfg.vco_output_divide_field, 2'h3);
		for (int i = 0; i <= 5; i++) begin
			wr(10'h08c, 8'(i));
			check("ref ratio", pll_cfg.reference_divide_ratio, 6'd1 << i);
		end
		wr(10'h08c, 8'h06);
		check("ref six dropped", pll_cfg.reference_divide_ratio, 6'd32);
		wr(10'h085, 8'h06);
		check("loop min", pll_cfg.loop_divide_ratio, 8'h06);
		wr(10'h085, 8'h05);
		check("loop below", pll_cfg.loop_divide_ratio, 8'h06);
		wr(10'h085, 8'h7f);
		check("loop max", pll_cfg.loop_divide_ratio, 8'h7f);
		wr(10'h085, 8'h80);
		rd(10'h085, rv); check("loop above", rv, 8'h7f);
		$display("test dividers done");
	endtask

	task automatic t_enable_cp();
		check("enable before", pll_cfg.enable, 1'b0);
		wr(10'h083, 8'h10);
		check("enable", pll_cfg.enable, 1'b1);
		check("cp run", cp_cal_run, 1'b1);
		for (int i = 0; i < 64; i++) begin
			if (i == 63) begin
				rd(10'h084, rv);
				check("cp not done", rv[5], 1'b0);
			end
			@(negedge sys_clk);
			ref_tick = 1'b1;
			@(negedge sys_clk);
			ref_tick = 1'b0;
		end
		cycles(1);
		rd(10'h084, rv); check("cp done", rv[5], 1'b1);
		check("cp stopped", cp_cal_run, 1'b0);
		wr(10'h083, 8'h00);
		wr(10'h083, 8'h10);
		check("cp held", cp_cal_run, 1'b0);
		$display("test enable and charge pump done");
	endtask

	task automatic t_recal();
		wr(10'h083, 8'h90);
		check("recal pulse", pll_cfg.recal_pulse, 1'b1);
		cycles(1);
		check("recal one cycle", pll_cfg.recal_pulse, 1'b0);
		wr(10'h083, 8'h90);
		check("no recal on hold", pll_cfg.recal_pulse, 1'b0);
		$display("test recalibration done");
	endtask

	task automatic t_irq_status();
		wr(10'h01f, 8'h20);
		pll_stat = 3'b001;
		cycles(2);
		rd(10'h023, rv); check("lock event", rv, 8'h20);
		pll_stat = 3'b000;
		cycles(2);
		rd(10'h023, rv); check("lost masked", rv, 8'h20);
		wr(10'h023, 8'h20);
		rd(10'h023, rv); check("lock cleared", rv, 8'h00);
		wr(10'h01f, 8'h30);
		rd(10'h01f, rv); check("irq enable", rv, 8'h30);
		pll_stat = 3'b101;
		cycles(2);
		rd(10'h084, rv); check("status up lock", rv, 8'ha2);
		pll_stat = 3'b010;
		cycles(2);
		rd(10'h084, rv); check("status low", rv, 8'h60);
		rd(10'h023, rv); check("both events", rv, 8'h30);
		wr(10'h023, 8'h10);
		rd(10'h023, rv); check("lost cleared", rv, 8'h20);
		wr(10'h023, 8'h20);
		rd(10'h023, rv); check("all cleared", rv, 8'h00);
		$display("test interrupt status done");
	endtask

	task automatic t_gain_power();
		wr(10'h040, 8'h03);
		wr(10'h041, 8'ha5);
		wr(10'h044, 8'h02);
		wr(10'h045, 8'h5a);
		check("gain0", full_scale_gain_code[0], 10'h3a5);
		check("gain1", full_scale_gain_code[1], 10'h25a);
		rd(10'h041, rv); check("gain0 lsb", rv, 8'ha5);
		rd(10'h044, rv); check("gain1 msb", rv, 8'h02);
		wr(10'h011, 8'h40);
		check("pd dac0", dac_power_down, 2'b01);
		wr(10'h011, 8'h10);
		check("pd dac1", dac_power_down, 2'b10);
		wr(10'h011, 8'h50);
		$display("test gain and power done");
	endtask

	task automatic t_selfcal();
		int n;
		cal_fault = {3'h5, 3'h0};
		wr(10'h0e7, 8'h38);
		check("cal clock on", cal_clock_run, 1'b1);
		wr(10'h0e8, 8'h05);
		wr(10'h0ed, 8'ha2);
		check("cal init", cal_initial_code, 8'ha2);
		wr(10'h0e9, 8'h01);
		check("armed only", cal_running, 2'b00);
		wr(10'h0e9, 8'h03);
		check("cal running", cal_running, 2'b11);
		n = 0;
		while (cal_running !== 2'b00 && n < 50) begin
			cycles(1);
			n++;
		end
		if (n >= 50) begin
			fails++;
			close_out();
		end else begin
			wr(10'h0e7, 8'h30);
			check("cal clock off", cal_clock_run, 1'b0);
			wr(10'h0e8, 8'h01);
			rd(10'h0e9, rv); check("dac0 result", rv, 8'h83);
			wr(10'h0e8, 8'h04);
			rd(10'h0e9, rv); check("dac1 result", rv, 8'hd3);
			$display("test self calibration done");
		end
	endtask

	task automatic t_temp();
		temp_code_in = 16'h1234;
		wr(10'h134, 8'h01);
		check("capture while off", temp_capture_pulse, 1'b0);
		check("sensor off", temp_sensor_on, 1'b0);
		wr(10'h12f, 8'h01);
		check("sensor on", temp_sensor_on, 1'b1);
		wr(10'h134, 8'h01);
		check("capture pulse", temp_capture_pulse, 1'b1);
		temp_code_in = 16'h5678;
		rd(10'h132, rv); check("temp low", rv, 8'h34);
		rd(10'h133, rv); check("temp high", rv, 8'h12);
		rd(10'h134, rv); check("capture reads zero", rv, 8'h00);
		$display("test temperature done");
	endtask

	task automatic t_samples();
		logic [16:0] vec [3] = '{17'h0ffff, 17'h18000, 17'h17fff};
		logic [15:0] exp [3] = '{16'hffff, 16'h0000, 16'hffff};
		for (int i = 0; i < 3; i++) begin
			@(negedge sys_clk);
			twos_mode = vec[i][16];
			sample_in = vec[i][15:0];
			@(negedge sys_clk);
			check("sample", sample_code, exp[i]);
		end
		$display("test samples done");
	endtask

	initial begin
		sys_clk      = 1'b0;
		rst_n        = 1'b0;
		reg_addr     = 10'h000;
		reg_wdata    = 8'h00;
		reg_wr       = 1'b0;
		reg_rd       = 1'b0;
		ref_tick     = 1'b0;
		pll_stat     = 3'b000;
		cal_fault    = '0;
		temp_code_in = 16'h0000;
		twos_mode    = 1'b0;
		sample_in    = 16'h0000;
		fails        = 0;
		tests_run    = 0;
		cycles(3);
		rst_n = 1'b1;
		t_reset_values();
		t_dividers();
		t_enable_cp();
		t_recal();
		t_irq_status();
		t_gain_power();
		t_selfcal();
		t_temp();
		t_samples();
		close_out();
	end

endmodule // dpc_top_tb
